// file: hw/reject_code_encoder.sv
// priority encoder from reject causes to six-bit reject code
// assumes one or more causes may be raised in one cycle
`timescale 1ns/1ps
`include "tape_error_status_map.svh"
module reject_code_encoder (
  fault_report_if.encoder rep
);
  import tape_error_status_pkg::*;

  always_comb begin
    rep.code       = `TES_CODE_NONE;
    rep.incomplete = 1'b0;
    if (rep.cause[`TES_RC_READY_DROP]) begin
      rep.code       = `TES_CODE_READY_DROP;
      rep.incomplete = 1'b1;
    end else if (rep.cause[`TES_RC_CACHE_EMPTY]) begin
      rep.code       = `TES_CODE_CACHE_EMPTY;
      rep.incomplete = 1'b1;
    end else if (rep.cause[`TES_RC_NOISE]) begin
      rep.code       = `TES_CODE_NOISE;
      rep.incomplete = 1'b1;
    end else if (rep.cause[`TES_RC_WRITE_FAIL]) begin
      rep.code       = `TES_CODE_WRITE_FAIL;
      rep.incomplete = 1'b1;
    end else if (rep.cause[`TES_RC_ID_BURST]) begin
      rep.code       = `TES_CODE_ID_BURST;
      rep.incomplete = 1'b1;
    end else if (rep.cause[`TES_RC_READ_FAIL]) begin
      rep.code       = `TES_CODE_READ_FAIL;
      rep.incomplete = 1'b1;
    end else if (rep.cause[`TES_RC_ERASE_FAIL]) begin
      rep.code       = `TES_CODE_ERASE_FAIL;
      rep.incomplete = 1'b1;
    end else if (rep.cause[`TES_RC_ACK_TIMEOUT]) begin
      rep.code       = `TES_CODE_ACK_TIMEOUT;
      rep.incomplete = 1'b1;
    end else if (rep.cause[`TES_RC_ILLEGAL_SEQ]) begin
      rep.code = `TES_CODE_ILLEGAL_SEQ;
    end else if (rep.cause[`TES_RC_FILE_PROTECT]) begin
      rep.code = `TES_CODE_FILE_PROTECT;
    end else if (rep.cause[`TES_RC_NOT_READY]) begin
      rep.code = `TES_CODE_NOT_READY;
    end
  end
endmodule // reject_code_encoder

// file: hw/tape_error_status_mux.sv
// error, reject and motion status of the tape unit on a nine-line bus
// assumes fault inputs are one-cycle events synchronous to sys_clk
`timescale 1ns/1ps
`include "tape_error_status_map.svh"
module tape_error_status_mux #(
  parameter int unsigned ACK_TIMEOUT_CYCLES = `TES_ACK_TIMEOUT_CYC
) (
  input  wire logic                                sys_clk,
  input  wire logic                                rst,
  input  wire logic                                cmdAccept,
  input  wire logic                                cmdGcr,
  input  wire logic                                cmdRead,
  input  wire logic                                cmdWrite,
  input  wire logic                                cmdBackward,
  input  wire logic                                cmdMotion,
  input  wire logic                                checkCharMismatch,
  input  wire logic                                bufferCheckBad,
  input  wire logic                                markWriteBad,
  input  wire logic                                markReadable,
  input  wire logic                                uncorrectableSeen,
  input  wire logic                                gapBeforeEnd,
  input  wire logic                                multiTrackSeen,
  input  wire logic                                multiTrackUncorr,
  input  wire logic                                blockEndBad,
  input  wire logic                                speedOutOfRange,
  input  wire logic                                diagModeSet,
  input  wire logic                                tapeTachometer,
  input  wire logic                                diagAid76In0,
  input  wire logic                                diagAid76In1,
  input  wire logic                                singleTrackCorrected,
  input  wire logic                                doubleTrackCorrected,
  input  wire logic                                singleTrackWriteErr,
  input  wire tape_error_status_pkg::reject_cause_t rejectCause,
  input  wire logic                                transferRequest,
  input  wire logic                                transferAcknowledge,
  input  wire logic                                writeStatusLine,
  input  wire logic                                endOfTapeLine,
  input  wire logic                                loadPointLine,
  input  wire logic                                fileProtectLine,
  input  wire logic                                highDensityLine,
  input  wire logic                                readyLine,
  input  wire logic                                onlineLine,
  input  wire logic [2:0]                          byteSelect,
  output logic [8:0]                               errorStatusBus,
  output logic                                     dataFaultLine,
  output logic                                     commandRefused,
  output logic                                     unfinishedOperationFlag,
  output logic                                     correctedFaultLine
);
  import tape_error_status_pkg::*;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic stickyNext(input logic cur, input logic set, input logic clr);
    stickyNext = set | (cur & ~clr);
  endfunction

  fault_report_if rep ();

  logic       checkCharFault_reg;
  logic       markWriteFault_reg;
  logic       uncorrectableFault_reg;
  logic       shortBlockFault_reg;
  logic       multiTrackFault_reg;
  logic       blockEndFault_reg;
  logic       speedFault_reg;
  logic       reverseMotion_reg;
  reject_code_t rejectCode_reg;
  ack_state_t ackState_reg;
  logic [31:0] ackCount_reg;
  logic       ackTimeout;
  logic       gcrRead;
  logic       checkCharSet;
  logic       markDataSet;
  logic       multiDataSet;
  logic       dataSet;
  logic       correctedSet;
  status_byte_t faultByte;
  status_byte_t diagByte;
  status_byte_t unitByte;

  assign gcrRead = cmdGcr & cmdRead;

  // ****************************************
  // read_write_fault_byte
  // ****************************************
  // mode-gated check character
  assign checkCharSet = (checkCharMismatch & (cmdGcr | cmdWrite)) | bufferCheckBad;
  assign markDataSet  = markWriteBad & markReadable;
  assign multiDataSet = multiTrackSeen & (~gcrRead | multiTrackUncorr);
  assign dataSet = (checkCharMismatch & (cmdGcr | cmdWrite)) | markDataSet
                 | uncorrectableSeen | gapBeforeEnd | multiDataSet | blockEndBad
                 | (speedOutOfRange & cmdWrite);

  // clear on command accept, set wins
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      checkCharFault_reg     <= 1'b0;
      markWriteFault_reg     <= 1'b0;
      uncorrectableFault_reg <= 1'b0;
      shortBlockFault_reg    <= 1'b0;
      multiTrackFault_reg    <= 1'b0;
      blockEndFault_reg      <= 1'b0;
      speedFault_reg         <= 1'b0;
    end else begin
      checkCharFault_reg     <= stickyNext(checkCharFault_reg, checkCharSet, cmdAccept);
      markWriteFault_reg     <= stickyNext(markWriteFault_reg, markWriteBad, cmdAccept);
      uncorrectableFault_reg <= stickyNext(uncorrectableFault_reg, uncorrectableSeen,
                                           cmdAccept);
      shortBlockFault_reg    <= stickyNext(shortBlockFault_reg, gapBeforeEnd, cmdAccept);
      multiTrackFault_reg    <= stickyNext(multiTrackFault_reg, multiTrackSeen, cmdAccept);
      blockEndFault_reg      <= stickyNext(blockEndFault_reg, blockEndBad, cmdAccept);
      speedFault_reg         <= stickyNext(speedFault_reg, speedOutOfRange & cmdWrite,
                                           cmdAccept);
    end
  end

  // ****************************************
  // separate status lines
  // ****************************************
  // corrected cases
  assign correctedSet = (singleTrackCorrected & cmdRead)
                      | (doubleTrackCorrected & gcrRead)
                      | (singleTrackWriteErr & cmdGcr & cmdWrite);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      dataFaultLine      <= 1'b0;
      commandRefused     <= 1'b0;
      correctedFaultLine <= 1'b0;
    end else begin
      dataFaultLine      <= stickyNext(dataFaultLine, dataSet, cmdAccept);
      commandRefused     <= stickyNext(commandRefused,
                                       (markWriteBad & ~markReadable) | (|rep.code),
                                       cmdAccept);
      correctedFaultLine <= stickyNext(correctedFaultLine, correctedSet, cmdAccept);
    end
  end

  // ****************************************
  // write acknowledge timer
  // ****************************************
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ackState_reg <= ACK_IDLE;
      ackCount_reg <= 32'h00000000;
    end else begin
      case (ackState_reg)
        ACK_IDLE: begin
          ackCount_reg <= 32'h00000000;
          if (cmdAccept & cmdWrite) begin
            ackState_reg <= ACK_WAIT;
          end
        end
        ACK_WAIT: begin
          if (cmdAccept & cmdWrite) begin
            ackCount_reg <= 32'h00000000;
          end else if (transferAcknowledge | cmdAccept | ackTimeout) begin
            ackState_reg <= ACK_IDLE;
          end else if (transferRequest) begin
            ackCount_reg <= ackCount_reg + 32'h00000001;
          end
        end
        default: begin
          ackState_reg <= ACK_IDLE;
        end
      endcase
    end
  end

  assign ackTimeout = (ackState_reg == ACK_WAIT) & transferRequest & ~transferAcknowledge
                    & (ackCount_reg == ACK_TIMEOUT_CYCLES - 1);

  // ****************************************
  // reject code
  // ****************************************
  always_comb begin
    rep.cause = rejectCause;
    rep.cause[`TES_RC_ACK_TIMEOUT] = rejectCause[`TES_RC_ACK_TIMEOUT] | ackTimeout;
  end

  reject_code_encoder encoder (
    .rep (rep)
  );

  // first reject of a command kept
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rejectCode_reg          <= `TES_CODE_NONE;
      unfinishedOperationFlag <= 1'b0;
    end else if (|rep.code && (cmdAccept || rejectCode_reg == `TES_CODE_NONE)) begin
      rejectCode_reg          <= rep.code;
      unfinishedOperationFlag <= rep.incomplete;
    end else if (cmdAccept) begin
      rejectCode_reg          <= `TES_CODE_NONE;
      unfinishedOperationFlag <= 1'b0;
    end
  end

  // ****************************************
  // motion direction
  // ****************************************
  // latch direction of motion commands
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      reverseMotion_reg <= 1'b0;
    end else if (cmdAccept & cmdMotion) begin
      reverseMotion_reg <= cmdBackward;
    end
  end

  // ****************************************
  // byte assembly and bus
  // ****************************************
  // fixed placement
  always_comb begin
    faultByte = 9'h000;
    faultByte[`TES_B1_CHECK_CHAR]    = checkCharFault_reg;
    faultByte[`TES_B1_MARK_WRITE]    = markWriteFault_reg;
    faultByte[`TES_B1_UNCORRECTABLE] = uncorrectableFault_reg;
    faultByte[`TES_B1_SHORT_BLOCK]   = shortBlockFault_reg;
    faultByte[`TES_B1_MULTI_TRACK]   = multiTrackFault_reg;
    faultByte[`TES_B1_BLOCK_END]     = blockEndFault_reg;
    faultByte[`TES_B1_SPEED]         = speedFault_reg;
    faultByte[`TES_B1_DIAG_LATCH]    = diagModeSet;
  end

  assign diagByte = {tapeTachometer, diagAid76In1 & diagModeSet,
                     diagAid76In0 & diagModeSet, rejectCode_reg};

  always_comb begin
    unitByte = 9'h000;
    unitByte[`TES_B3_WRITE_STATUS] = writeStatusLine;
    unitByte[`TES_B3_END_OF_TAPE]  = endOfTapeLine;
    unitByte[`TES_B3_LOAD_POINT]   = loadPointLine;
    unitByte[`TES_B3_FILE_PROTECT] = fileProtectLine;
    unitByte[`TES_B3_REVERSE]      = reverseMotion_reg;
    unitByte[`TES_B3_HIGH_DENSITY] = highDensityLine;
    unitByte[`TES_B3_READY]        = readyLine;
    unitByte[`TES_B3_ONLINE]       = onlineLine;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      errorStatusBus <= 9'h000;
    end else if (byteSelect == `TES_SEL_FAULT_BYTE) begin
      errorStatusBus <= faultByte;
    end else if (byteSelect == `TES_SEL_DIAG_BYTE) begin
      errorStatusBus <= diagByte;
    end else if (byteSelect == `TES_SEL_UNIT_BYTE) begin
      errorStatusBus <= unitByte;
    end else begin
      errorStatusBus <= 9'h000;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  sequence seqAccept;
    cmdAccept && rep.code == `TES_CODE_NONE;
  endsequence

  sequence seqSelFault;
    byteSelect == `TES_SEL_FAULT_BYTE;
  endsequence

  AST_UNCORR_DATA: assert property (@(posedge sys_clk) disable iff (rst)
    uncorrectableSeen |=> dataFaultLine && uncorrectableFault_reg)
    else $error("uncorrectable fault without data line");
  AST_MULTI_GCR_READ: assert property (@(posedge sys_clk) disable iff (rst)
    ((seqAccept and !dataSet) ##1 (multiTrackSeen && gcrRead && !multiTrackUncorr
    && !(checkCharMismatch || markWriteBad || uncorrectableSeen || gapBeforeEnd || blockEndBad)))
    |=> !dataFaultLine)
    else $error("gcr read multi-track raised data line");
  AST_SPEED_READ: assert property (@(posedge sys_clk) disable iff (rst)
    (speedOutOfRange && !cmdWrite && !speedFault_reg) |=> !speedFault_reg)
    else $error("speed fault set outside write");
  AST_CLEAR: assert property (@(posedge sys_clk) disable iff (rst)
    (seqAccept and !(checkCharSet || markWriteBad)) |=> !checkCharFault_reg
    && !markWriteFault_reg && rejectCode_reg == `TES_CODE_NONE)
    else $error("command accept did not clear faults");
  AST_BYTE1: assert property (@(posedge sys_clk) disable iff (rst)
    seqSelFault |=> errorStatusBus[3] == 1'b0
    && errorStatusBus[`TES_B1_SPEED] == $past(speedFault_reg))
    else $error("byte 1 placement wrong");
  AST_TAPE_TACHOMETER_BIT: assert property (@(posedge sys_clk) disable iff (rst)
    byteSelect == `TES_SEL_DIAG_BYTE |=> errorStatusBus[8] == $past(tapeTachometer))
    else $error("tachometer not on parity bit");
  AST_NOT_READY: assert property (@(posedge sys_clk) disable iff (rst)
    (rejectCause == 11'h001 && !ackTimeout && (rejectCode_reg == `TES_CODE_NONE))
    |=> rejectCode_reg == `TES_CODE_NOT_READY && !unfinishedOperationFlag)
    else $error("not ready code wrong");
  AST_ACK_TIMEOUT: assert property (@(posedge sys_clk) disable iff (rst)
    (ackTimeout && rejectCause == 11'h000 && rejectCode_reg == `TES_CODE_NONE)
    |=> rejectCode_reg == `TES_CODE_ACK_TIMEOUT && unfinishedOperationFlag)
    else $error("acknowledge timeout not reported");
  AST_REVERSE: assert property (@(posedge sys_clk) disable iff (rst)
    (cmdAccept && cmdMotion) |=> reverseMotion_reg == $past(cmdBackward))
    else $error("reverse flag not following direction");
endmodule // tape_error_status_mux

// file: inc/fault_report_if.sv
// carries reject causes to the encoder and the code back
// assumes both ends sit on the same clock
`timescale 1ns/1ps
interface fault_report_if;
  import tape_error_status_pkg::*;
  reject_cause_t cause;
  reject_code_t  code;
  logic          incomplete;
  modport encoder (input cause, output code, output incomplete);
  modport sink    (output cause, input code, input incomplete);
endinterface

// file: inc/tape_error_status_map.svh
// constants for the tape error and reject status multiplexer
// assumes a 100 MHz system clock; included by bare name
`ifndef TAPE_ERROR_STATUS_MAP_SVH
`define TAPE_ERROR_STATUS_MAP_SVH

// ****************************************
// timing
// ****************************************
`define TES_CLK_MHZ            100
`define TES_ACK_TIMEOUT_MS     75
`define TES_ACK_TIMEOUT_CYC    (`TES_ACK_TIMEOUT_MS * 1000 * `TES_CLK_MHZ)

// ****************************************
// byte select codes
// ****************************************
`define TES_SEL_DEAD_TRACK     3'h0
`define TES_SEL_FAULT_BYTE     3'h1
`define TES_SEL_DIAG_BYTE      3'h2
`define TES_SEL_UNIT_BYTE      3'h3

// ****************************************
// read_write_fault_byte positions
// ****************************************
`define TES_B1_CHECK_CHAR      8
`define TES_B1_MARK_WRITE      7
`define TES_B1_UNCORRECTABLE   6
`define TES_B1_SHORT_BLOCK     5
`define TES_B1_MULTI_TRACK     4
`define TES_B1_BLOCK_END       2
`define TES_B1_SPEED           1
`define TES_B1_DIAG_LATCH      0

// ****************************************
// unit_state_byte positions
// ****************************************
`define TES_B3_WRITE_STATUS    8
`define TES_B3_END_OF_TAPE     7
`define TES_B3_LOAD_POINT      6
`define TES_B3_FILE_PROTECT    4
`define TES_B3_REVERSE         3
`define TES_B3_HIGH_DENSITY    2
`define TES_B3_READY           1
`define TES_B3_ONLINE          0

// ****************************************
// reject cause indices, highest index wins
// ****************************************
`define TES_RC_NOT_READY       0
`define TES_RC_FILE_PROTECT    1
`define TES_RC_ILLEGAL_SEQ     2
`define TES_RC_ACK_TIMEOUT     3
`define TES_RC_ERASE_FAIL      4
`define TES_RC_READ_FAIL       5
`define TES_RC_ID_BURST        6
`define TES_RC_WRITE_FAIL      7
`define TES_RC_NOISE           8
`define TES_RC_CACHE_EMPTY     9
`define TES_RC_READY_DROP      10

// ****************************************
// reject code values
// ****************************************
`define TES_CODE_NONE          6'h00
`define TES_CODE_NOT_READY     6'h01
`define TES_CODE_ACK_TIMEOUT   6'h03
`define TES_CODE_FILE_PROTECT  6'h05
`define TES_CODE_ERASE_FAIL    6'h06
`define TES_CODE_ILLEGAL_SEQ   6'h07
`define TES_CODE_READ_FAIL     6'h08
`define TES_CODE_ID_BURST      6'h09
`define TES_CODE_WRITE_FAIL    6'h0C
`define TES_CODE_NOISE         6'h0F
`define TES_CODE_CACHE_EMPTY   6'h10
`define TES_CODE_READY_DROP    6'h11

`endif

// file: inc/tape_error_status_pkg.sv
// types for the tape error and reject status multiplexer
// assumes the constants header is included alongside
package tape_error_status_pkg;
  typedef logic [10:0] reject_cause_t;
  typedef logic [5:0]  reject_code_t;
  typedef logic [8:0]  status_byte_t;
  typedef enum logic [1:0] {
    ACK_IDLE = 2'b00,
    ACK_WAIT = 2'b01
  } ack_state_t;
endpackage

// file: test/host_ack_model.sv
// host side model answering the device transfer request
// assumes it shares sys_clk and rst with the device
`timescale 1ns/1ps
module host_ack_model (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       transferRequest,
  input  wire logic [7:0] ackDelay,
  output logic            transferAcknowledge
);
  logic [7:0] waitCnt_reg;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      waitCnt_reg <= 8'h00;
      transferAcknowledge <= 1'b0;
    end else begin
      waitCnt_reg <= transferRequest ? waitCnt_reg + 8'h01 : 8'h00;
      transferAcknowledge <= transferRequest && (waitCnt_reg >= ackDelay);
    end
  end
endmodule // host_ack_model

// file: test/tape_error_status_mux_tb.sv
// self-checking bench for the tape error status multiplexer
// assumes the package, header and host model are compiled first
`timescale 1ns/1ps
module tape_error_status_mux_tb;
  import tape_error_status_pkg::*;
  localparam int ACK = 20;
  logic sys_clk = 0, rst = 1, cmdAccept = 0, cmdGcr = 0, cmdRead = 0, cmdWrite = 0;
  logic cmdBackward = 0, cmdMotion = 0, markReadable = 1, multiTrackUncorr = 0, diagModeSet = 0;
  logic tapeTachometer = 0, diagAid76In0 = 0, diagAid76In1 = 0, transferRequest = 0;
  logic doubleTrackCorrected = 0, singleTrackWriteErr = 0, writeStatusLine = 0;
  logic endOfTapeLine = 0, loadPointLine = 0, fileProtectLine = 0, highDensityLine = 0;
  logic readyLine = 0, onlineLine = 0, transferAcknowledge;
  logic [8:0] ev = 9'h000;
  logic [7:0] ackDelay = 8'h05;
  logic [2:0] byteSelect = 3'h0;
  reject_cause_t rejectCause = 11'h000;
  logic [8:0] errorStatusBus;
  logic dataFaultLine, commandRefused, unfinishedOperationFlag, correctedFaultLine;
  logic [12:0] notes[$];
  logic [31:0] rng = 32'h8242;
  int err_count = 0, cmp_count = 0;
  int pos[8] = '{8, 8, 7, 6, 5, 4, 2, 1};
  reject_code_t codes[11] = '{6'h01, 6'h05, 6'h07, 6'h03, 6'h06, 6'h08, 6'h09, 6'h0C, 6'h0F,
                              6'h10, 6'h11};
  always #5 sys_clk = ~sys_clk;
  tape_error_status_mux #(.ACK_TIMEOUT_CYCLES(ACK)) tape_error_status_mux_i (
    .sys_clk, .rst, .cmdAccept, .cmdGcr, .cmdRead, .cmdWrite, .cmdBackward, .cmdMotion,
    .checkCharMismatch(ev[0]), .bufferCheckBad(ev[1]), .markWriteBad(ev[2]), .markReadable,
    .uncorrectableSeen(ev[3]), .gapBeforeEnd(ev[4]), .multiTrackSeen(ev[5]), .multiTrackUncorr,
    .blockEndBad(ev[6]), .speedOutOfRange(ev[7]), .diagModeSet, .tapeTachometer, .diagAid76In0,
    .diagAid76In1, .singleTrackCorrected(ev[8]), .doubleTrackCorrected, .singleTrackWriteErr,
    .rejectCause, .transferRequest, .transferAcknowledge, .writeStatusLine, .endOfTapeLine,
    .loadPointLine, .fileProtectLine, .highDensityLine, .readyLine, .onlineLine, .byteSelect,
    .errorStatusBus, .dataFaultLine, .commandRefused, .unfinishedOperationFlag,
    .correctedFaultLine);
  host_ack_model host_ack_model_i (.sys_clk, .rst, .transferRequest, .ackDelay,
    .transferAcknowledge);
  // ****************************************
  // drivers and scoreboard
  // ****************************************
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction
  task automatic accept(input logic wr, gcr, rd, mot, bwd);
    {cmdWrite, cmdGcr, cmdRead, cmdMotion, cmdBackward} = {wr, gcr, rd, mot, bwd};
    cmdAccept = 1'b1;
    @(negedge sys_clk);
    cmdAccept = 1'b0;
  endtask
  task automatic pulse(input int i);
    ev[i] = 1'b1;
    @(negedge sys_clk);
    ev[i] = 1'b0;
  endtask
  task automatic note(input logic [2:0] sel, input logic [8:0] bus, input logic [3:0] ln);
    byteSelect = sel;
    repeat (2) @(posedge sys_clk);
    notes.push_back({bus, ln});
    @(negedge sys_clk);
  endtask
  task automatic cmp_status(input logic [12:0] exp, got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t status exp %h got %h", $time, exp, got);
    end
  endtask
  always @(negedge sys_clk)
    while (notes.size() > 0)
      cmp_status(notes.pop_front(), {errorStatusBus, dataFaultLine, commandRefused,
                 unfinishedOperationFlag, correctedFaultLine});
  task automatic conclude();
    $display("checks %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #100000;
    err_count++;
    conclude();
  end
  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    repeat (5) @(posedge sys_clk);
    @(negedge sys_clk);
    rst = 1'b0;
    for (int s = 0; s < 8; s++) note(s[2:0], 9'h000, 4'h0);
    for (int i = 0; i < 8; i++) begin
      accept(1, 0, 0, 0, 0);
      note(3'h1, 9'h000, 4'h0);
      pulse(i);
      note(3'h1, 9'h001 << pos[i],
           {i != 1, 3'h0});
    end
    markReadable = 1'b0;
    accept(1, 0, 0, 0, 0);
    pulse(2);
    note(3'h1, 9'h080, 4'h4);
    accept(0, 1, 1, 0, 0);
    pulse(5);
    note(3'h1, 9'h010, 4'h0);
    accept(0, 0, 1, 0, 0);
    pulse(8);
    note(3'h5, 9'h000, 4'h1);
    accept(0, 1, 1, 0, 0);
    {doubleTrackCorrected, ev[7], ev[0]} = 3'b111;
    @(negedge sys_clk);
    {doubleTrackCorrected, ev[7], ev[0]} = 3'b000;
    note(3'h1, 9'h100, 4'h9);
    accept(1, 1, 0, 0, 0);
    singleTrackWriteErr = 1'b1;
    @(negedge sys_clk);
    singleTrackWriteErr = 1'b0;
    note(3'h1, 9'h000, 4'h1);
    diagAid76In1 = 1'b1;
    for (int i = 0; i < 11; i++) begin
      tapeTachometer = rng[0];
      rng = xs(rng);
      accept(0, 0, 0, 0, 0);
      rejectCause = 11'h001 << i;
      @(negedge sys_clk);
      rejectCause = 11'h000;
      note(3'h2, {tapeTachometer, 2'b00, codes[i]}, {2'b01, i >= 3, 1'b0});
    end
    diagModeSet = 1'b1;
    note(3'h2, {tapeTachometer, 2'b10, 6'h11}, 4'h6);
    note(3'h1, 9'h001, 4'h6);
    note(3'h7, 9'h000, 4'h6);
    diagModeSet = 1'b0;
    for (int i = 0; i < 4; i++) begin
      rng = xs(rng);
      {writeStatusLine, endOfTapeLine, loadPointLine, fileProtectLine, highDensityLine,
       readyLine, onlineLine} = rng[6:0];
      accept(0, 0, 0, 1, i[0]);
      note(3'h3, {rng[6:4], 1'b0, rng[3], i[0], rng[2:0]}, 4'h0);
    end
    for (int i = 0; i < 2; i++) begin
      ackDelay = i ? 8'hC8 : 8'h05;
      accept(1, 0, 0, 0, 0);
      transferRequest = 1'b1;
      repeat (ACK + 5) @(negedge sys_clk);
      transferRequest = 1'b0;
      note(3'h2, {tapeTachometer, 2'b00, i ? 6'h03 : 6'h00}, i ? 4'h6 : 4'h0);
    end
    conclude();
  end
endmodule // tape_error_status_mux_tb
